// ==== ulm_status.sv ====
// Line status, modem status, receive FIFO, transmit holding byte,
// prescaler and half-duplex RTS control of one serial channel.
// Assumes a receiver core, a transmitter core and a host port on i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ulm_consts.svh"

// What this block does
// - Prescaler bit picks undivided or divide-by-four baud enable; default undivided.
// - Line status interrupt enable raises request while FIFO holds errored characters.
// - Data ready flag is high while any received character waits.
// - Character arriving at full FIFO sets overrun and is dropped.
// - Parity error flag belongs to the character at the FIFO head.
// - Framing error flag belongs to the character at the FIFO head.
// - Break loads one character and the flag holds until line idles.
// - Holding empty flag clears on host load, sets on transfer; can interrupt.
// - Transmitter empty flag is high only when holding and shifter are empty.
// - FIFO error summary is high while any stored character carries errors.
// - CTS, DSR and CD changes set delta flags; enable bit 3 interrupts.
// - RI delta sets only when RI input rises, ending the ring.
// - Auto CTS stops sending after current character while CTS input high and modem control bit 2 is clear.
// - Outside loopback status bits 4 to 7 are inverted modem inputs.
// - In loopback status bits 4 to 7 mirror modem control RTS, DTR, 2, 3.
// - Auto RS-485 delays RTS turnaround by zero to fifteen bit times.
// - Turnaround delay field is writable only while enhanced enable is set.
// - Scratch register is eight bits and resets to all ones.
// - Auto RS-485 drives RTS low after last stop bit, high on load.
// - Modem control loopback bit selects local loopback; default normal.
module ulm_status #(
	parameter int RX_DEPTH = 64
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Host register port.
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [7:0] o_rdata,
	// Receiver core.
	input wire ulm_pkg::ulm_rx_evt_t i_rx,
	input wire logic i_rx_line,
	// Transmitter core.
	input wire ulm_pkg::ulm_tx_stat_t i_tx,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	// Modem lines.
	input wire ulm_pkg::ulm_modem_in_t i_modem,
	output logic o_rts_n,
	output logic o_dtr_n,
	output logic o_loopback,
	// Baud enable and interrupt requests.
	output logic o_baud_en,
	output logic o_line_irq,
	output logic o_thr_irq,
	output logic o_modem_irq
);
	import ulm_pkg::*;

	localparam int AW = $clog2(RX_DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(RX_DEPTH);

	logic [7:0] ie_r, mc_r, fc_r, ef_r, sp_r;
	logic [3:0] dly_r;
	logic [1:0] pre_cnt_r;
	ulm_rx_word_t mem [RX_DEPTH];
	logic [AW-1:0] wr_ptr_r, rd_ptr_r;
	logic [AW:0] cnt_r, err_cnt_r;
	logic ovr_r, brk_hold_r;
	logic thr_full_r, thr_full_nxt;
	logic [7:0] thr_r;
	logic [3:0] ms_prev_r, delta_r, ms_now, chg;
	logic prev_ok_r;
	ulm_rts_state_t rts_st_r, rts_st_nxt;
	logic [3:0] hold_cnt_r;
	ulm_rx_word_t head;
	logic wr, rd, empty, full, push, pop, push_err, pop_err;
	logic cts_stop, auto485, tsr_empty;
	logic [7:0] ls_val, rd_nxt;

	// Access decode and FIFO status.
	assign wr = i_we;
	assign rd = i_re;
	assign empty = (cnt_r == '0);
	assign full = (cnt_r == FULL_CNT);
	assign head = mem[rd_ptr_r];
	assign auto485 = fc_r[`ULM_FC_485];

	// Only one break character enters while the line stays low.
	assign push = i_rx.done && !full &&
		!(i_rx.brk && brk_hold_r);
	assign pop = rd && (i_addr == `ULM_OFS_DATA) && !empty;
	assign push_err = push && (i_rx.par_err || i_rx.frm_err || i_rx.brk);
	assign pop_err = pop && (head.par || head.frm || head.brk);

	// Control registers; upper modem control bits need enhanced enable.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ie_r <= `ULM_REG_RST;
			mc_r <= `ULM_REG_RST;
			fc_r <= `ULM_REG_RST;
			ef_r <= `ULM_REG_RST;
		end else if (wr) begin
			case (i_addr)
				`ULM_OFS_IE: ie_r <= i_wdata;
				`ULM_OFS_MC: begin
					if (ef_r[`ULM_EF_ENH]) begin
						mc_r <= i_wdata;
					end else begin
						mc_r <= {mc_r[7:5], i_wdata[4:0]};
					end
				end
				`ULM_OFS_FC: fc_r <= i_wdata;
				`ULM_OFS_EF: ef_r <= i_wdata;
				default: ;
			endcase
		end
	end

	// Scratch pad, all ones after reset.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sp_r <= `ULM_SP_RST;
		end else if (wr && (i_addr == `ULM_OFS_SP)) begin
			sp_r <= i_wdata;
		end
	end

	// Write-only turnaround delay, shares the modem status offset.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dly_r <= 4'h0;
		end else if (wr && (i_addr == `ULM_OFS_MS) &&
			ef_r[`ULM_EF_ENH]) begin
			dly_r <= i_wdata[7:4];
		end
	end

	// Prescaler: every cycle, or one cycle in four.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pre_cnt_r <= 2'h0;
			o_baud_en <= 1'b0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 2'h1;
			if (mc_r[`ULM_MC_PRE]) begin
				o_baud_en <= (pre_cnt_r == `ULM_PRE_LAST);
			end else begin
				o_baud_en <= 1'b1;
			end
		end
	end

	// Receive FIFO storage; RX_DEPTH must be a power of two.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= '{par: i_rx.par_err, frm: i_rx.frm_err,
				brk: i_rx.brk, data: i_rx.data};
		end
	end

	// Receive FIFO pointers and counts; overflow leaves contents intact.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			case ({push, pop})
				2'b10: cnt_r <= cnt_r + 1'b1;
				2'b01: cnt_r <= cnt_r - 1'b1;
				default: ;
			endcase
		end
	end

	// Count of stored characters that carry an error.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			err_cnt_r <= '0;
		end else begin
			case ({push_err, pop_err})
				2'b10: err_cnt_r <= err_cnt_r + 1'b1;
				2'b01: err_cnt_r <= err_cnt_r - 1'b1;
				default: ;
			endcase
		end
	end

	// Overrun is sticky until line status is read; a new one wins.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovr_r <= 1'b0;
		end else if (i_rx.done && full) begin
			ovr_r <= 1'b1;
		end else if (rd && (i_addr == `ULM_OFS_LS)) begin
			ovr_r <= 1'b0;
		end
	end

	// Break hold lasts until the receive line is back at mark.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			brk_hold_r <= 1'b0;
		end else if (i_rx.done && i_rx.brk) begin
			brk_hold_r <= 1'b1;
		end else if (i_rx_line) begin
			brk_hold_r <= 1'b0;
		end
	end

	// Transmit holding byte; auto CTS holds back the next character.
	assign cts_stop = ef_r[`ULM_EF_ACTS] && !mc_r[`ULM_MC_SEL] &&
		i_modem.cts_n;
	assign thr_full_nxt = (wr && (i_addr == `ULM_OFS_DATA)) ||
		(thr_full_r && !i_tx.take);
	assign tsr_empty = !thr_full_r && !i_tx.busy;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			thr_full_r <= 1'b0;
			thr_r <= 8'h00;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
		end else begin
			thr_full_r <= thr_full_nxt;
			if (wr && (i_addr == `ULM_OFS_DATA)) begin
				thr_r <= i_wdata;
				o_tx_data <= i_wdata;
			end
			o_tx_valid <= thr_full_nxt && !cts_stop;
		end
	end

	// Modem status bits, from pins or from modem control in loopback.
	always_comb begin
		if (mc_r[`ULM_MC_LOOP]) begin
			ms_now = {mc_r[`ULM_MC_OUT3], mc_r[`ULM_MC_SEL],
				mc_r[`ULM_MC_DTR], mc_r[`ULM_MC_RTS]};
		end else begin
			ms_now = ~{i_modem.cd_n, i_modem.ri_n,
				i_modem.dsr_n, i_modem.cts_n};
		end
	end

	// RI counts only when its status bit falls, the pin rising.
	assign chg[0] = prev_ok_r && (ms_now[0] != ms_prev_r[0]);
	assign chg[1] = prev_ok_r && (ms_now[1] != ms_prev_r[1]);
	assign chg[2] = prev_ok_r && ms_prev_r[2] && !ms_now[2];
	assign chg[3] = prev_ok_r && (ms_now[3] != ms_prev_r[3]);

	// Delta flags clear on a status read unless a change lands with it.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ms_prev_r <= 4'h0;
			prev_ok_r <= 1'b0;
			delta_r <= 4'h0;
		end else begin
			ms_prev_r <= ms_now;
			prev_ok_r <= 1'b1;
			if (rd && (i_addr == `ULM_OFS_MS)) begin
				delta_r <= chg;
			end else begin
				delta_r <= delta_r | chg;
			end
		end
	end

	// Half-duplex direction control.
	always_comb begin
		rts_st_nxt = rts_st_r;
		case (rts_st_r)
			RTS_IDLE: begin
				if (thr_full_r) begin
					rts_st_nxt = RTS_SEND;
				end
			end
			RTS_SEND: begin
				if (i_tx.shift_done && !thr_full_r) begin
					if (dly_r == 4'h0) begin
						rts_st_nxt = RTS_IDLE;
					end else begin
						rts_st_nxt = RTS_HOLD;
					end
				end
			end
			RTS_HOLD: begin
				if (thr_full_r) begin
					rts_st_nxt = RTS_SEND;
				end else if (i_tx.bit_tick && hold_cnt_r == 4'h1) begin
					rts_st_nxt = RTS_IDLE;
				end
			end
			default: rts_st_nxt = RTS_IDLE;
		endcase
	end

	// Turnaround state, bit-time counter and modem outputs.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rts_st_r <= RTS_IDLE;
			hold_cnt_r <= 4'h0;
			o_rts_n <= 1'b1;
			o_dtr_n <= 1'b1;
			o_loopback <= 1'b0;
		end else begin
			rts_st_r <= rts_st_nxt;
			if (rts_st_r != RTS_HOLD) begin
				hold_cnt_r <= dly_r;
			end else if (i_tx.bit_tick) begin
				hold_cnt_r <= hold_cnt_r - 4'h1;
			end
			if (auto485) begin
				o_rts_n <= (rts_st_nxt != RTS_IDLE);
			end else begin
				o_rts_n <= !mc_r[`ULM_MC_RTS];
			end
			o_dtr_n <= !mc_r[`ULM_MC_DTR];
			o_loopback <= mc_r[`ULM_MC_LOOP];
		end
	end

	// Line status word.
	assign ls_val = {(err_cnt_r != '0),
		tsr_empty,
		!thr_full_r,
		(head.brk && !empty) || brk_hold_r,
		head.frm && !empty,
		head.par && !empty,
		ovr_r,
		!empty};

	// Read data multiplexer; unmapped offsets read zero.
	always_comb begin
		case (i_addr)
			`ULM_OFS_DATA: rd_nxt = empty ? 8'h00 : head.data;
			`ULM_OFS_IE: rd_nxt = ie_r;
			`ULM_OFS_MC: rd_nxt = mc_r;
			`ULM_OFS_LS: rd_nxt = ls_val;
			`ULM_OFS_MS: rd_nxt = {ms_now, delta_r};
			`ULM_OFS_SP: rd_nxt = sp_r;
			`ULM_OFS_FC: rd_nxt = fc_r;
			`ULM_OFS_EF: rd_nxt = ef_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 8'h00;
		end else if (rd) begin
			o_rdata <= rd_nxt;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Interrupt requests; auto RS-485 moves the transmit one to shift empty.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_line_irq <= 1'b0;
			o_thr_irq <= 1'b0;
			o_modem_irq <= 1'b0;
		end else begin
			o_line_irq <= ie_r[`ULM_IE_LS] &&
				((err_cnt_r != '0) || ovr_r);
			o_thr_irq <= ie_r[`ULM_IE_THR] &&
				(auto485 ? tsr_empty : !thr_full_r);
			o_modem_irq <= ie_r[`ULM_IE_MS] && (delta_r != 4'h0);
		end
	end

	property p_pre_div;
		@(posedge i_clk) disable iff (!i_arst_n)
		mc_r[`ULM_MC_PRE] && pre_cnt_r != `ULM_PRE_LAST |=> !o_baud_en;
	endproperty
	a_pre_div: assert property (p_pre_div) else $error("prescaler early");

	property p_line_irq;
		@(posedge i_clk) disable iff (!i_arst_n)
		ie_r[`ULM_IE_LS] && err_cnt_r != '0 |=> o_line_irq;
	endproperty
	a_line_irq: assert property (p_line_irq) else $error("no line irq");

	property p_ready;
		@(posedge i_clk) disable iff (!i_arst_n)
		rd && i_addr == `ULM_OFS_LS |=> o_rdata[0] == $past(!empty);
	endproperty
	a_ready: assert property (p_ready) else $error("bad data ready");

	property p_overrun;
		@(posedge i_clk) disable iff (!i_arst_n)
		i_rx.done && full && !pop |=> ovr_r && full && $stable(wr_ptr_r);
	endproperty
	a_overrun: assert property (p_overrun) else $error("bad overrun");

	property p_err_sum;
		@(posedge i_clk) disable iff (!i_arst_n)
		rd && i_addr == `ULM_OFS_LS |=> o_rdata[7] == $past(err_cnt_r != '0);
	endproperty
	a_err_sum: assert property (p_err_sum) else $error("bad error sum");

	property p_cts_delta;
		@(posedge i_clk) disable iff (!i_arst_n)
		chg[0] |=> delta_r[0];
	endproperty
	a_cts_delta: assert property (p_cts_delta) else $error("lost cts");

	property p_ri_rise;
		@(posedge i_clk) disable iff (!i_arst_n)
		prev_ok_r && !ms_prev_r[2] && ms_now[2] && !delta_r[2] |=> !delta_r[2];
	endproperty
	a_ri_rise: assert property (p_ri_rise) else $error("ri wrong edge");

	property p_acts;
		@(posedge i_clk) disable iff (!i_arst_n)
		cts_stop |=> !o_tx_valid;
	endproperty
	a_acts: assert property (p_acts) else $error("sent under cts");

	property p_loop;
		@(posedge i_clk) disable iff (!i_arst_n)
		rd && i_addr == `ULM_OFS_MS && mc_r[`ULM_MC_LOOP] |=>
			o_rdata[4] == $past(mc_r[`ULM_MC_RTS]);
	endproperty
	a_loop: assert property (p_loop) else $error("bad loopback");

	property p_dly_lock;
		@(posedge i_clk) disable iff (!i_arst_n)
		!(wr && i_addr == `ULM_OFS_MS && ef_r[`ULM_EF_ENH]) |=> $stable(dly_r);
	endproperty
	a_dly_lock: assert property (p_dly_lock) else $error("delay changed");

	property p_rts_up;
		@(posedge i_clk) disable iff (!i_arst_n)
		auto485 && rts_st_r == RTS_IDLE && thr_full_r |=> o_rts_n;
	endproperty
	a_rts_up: assert property (p_rts_up) else $error("rts not raised");

endmodule
`default_nettype wire

// ==== ulm_consts.svh ====
// Register offsets, field positions, reset values and counts of the
// line and modem status block.
// Assumes it is included by its bare name wherever the constants are used.
`ifndef ULM_CONSTS_SVH
`define ULM_CONSTS_SVH

// Register offsets on the host port.
`define ULM_OFS_DATA 4'h0
`define ULM_OFS_IE 4'h1
`define ULM_OFS_MC 4'h4
`define ULM_OFS_LS 4'h5
`define ULM_OFS_MS 4'h6
`define ULM_OFS_SP 4'h7
`define ULM_OFS_FC 4'h8
`define ULM_OFS_EF 4'h9

// Interrupt enable bits.
`define ULM_IE_THR 1
`define ULM_IE_LS 2
`define ULM_IE_MS 3

// Modem control bits.
`define ULM_MC_DTR 0
`define ULM_MC_RTS 1
`define ULM_MC_SEL 2
`define ULM_MC_OUT3 3
`define ULM_MC_LOOP 4
`define ULM_MC_PRE 7

// Feature control and enhanced feature bits.
`define ULM_FC_485 5
`define ULM_EF_ENH 4
`define ULM_EF_ACTS 7

// Reset values.
`define ULM_REG_RST 8'h00
`define ULM_SP_RST 8'hFF

// Last count of the divide-by-four prescaler.
`define ULM_PRE_LAST 2'h3

`endif

// ==== ulm_pkg.sv ====
// Types shared by the line and modem status block and its neighbours.
// Assumes the receiver and transmitter cores use these carriers.
package ulm_pkg;

	// One finished character from the receiver core.
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic par_err;
		logic frm_err;
		logic brk;
	} ulm_rx_evt_t;

	// Status of the transmitter core.
	typedef struct packed {
		logic take;
		logic busy;
		logic shift_done;
		logic bit_tick;
	} ulm_tx_stat_t;

	// Active-low modem inputs.
	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic ri_n;
		logic cd_n;
	} ulm_modem_in_t;

	// One word held in the receive FIFO.
	typedef struct packed {
		logic par;
		logic frm;
		logic brk;
		logic [7:0] data;
	} ulm_rx_word_t;

	// Direction states of the half-duplex RTS control.
	typedef enum logic [1:0] {
		RTS_IDLE,
		RTS_SEND,
		RTS_HOLD
	} ulm_rts_state_t;

endpackage

// ==== ulm_status_pad.sv ====
`timescale 1ns/1ps

// ==== ulm_far_model.sv ====
// Far side of the status block: receiver core, transmitter core and modem.
// Assumes the bench calls its tasks and reads its state hierarchically.
`timescale 1ns/1ps
`default_nettype none
module ulm_far_model (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// From the block.
	input wire logic i_tx_valid,
	input wire logic i_rts_n,
	// To the block.
	output var ulm_pkg::ulm_rx_evt_t o_rx,
	output logic o_rx_line,
	output var ulm_pkg::ulm_tx_stat_t o_tx,
	output var ulm_pkg::ulm_modem_in_t o_modem
);
	import ulm_pkg::*;
	logic hold;
	logic [1:0] ph;
	int n_bits;
	int since;
	int rts_lat;

	// Idle line, inactive modem inputs, transmitter free to take.
	initial begin
		o_rx = '0;
		o_rx_line = 1'b1;
		o_modem = '1;
		hold = 1'b0;
		since = 0;
		rts_lat = -1;
	end

	// Bit clock every 4 cycles; a taken byte shifts for 10 bit times.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph <= 2'h0;
			o_tx <= '0;
			n_bits <= 0;
		end else begin
			ph <= ph + 2'h1;
			o_tx.bit_tick <= (ph == 2'h3);
			o_tx.take <= i_tx_valid && !o_tx.take && !o_tx.busy && !hold;
			o_tx.shift_done <= o_tx.busy && o_tx.bit_tick && n_bits == 9;
			if (o_tx.take) begin
				o_tx.busy <= 1'b1;
				n_bits <= 0;
			end else if (o_tx.busy && o_tx.bit_tick) begin
				n_bits <= n_bits + 1;
				if (n_bits == 9)
					o_tx.busy <= 1'b0;
			end
		end
	end

	// Cycles from the end of the stop bit until RTS is seen low.
	always @(posedge i_clk) begin
		if (o_tx.shift_done)
			since <= 1;
		else if (since > 0 && i_rts_n)
			since <= since + 1;
		else if (since > 0) begin
			rts_lat <= since;
			since <= 0;
		end
	end

	// One finished character; stale fields are inverted afterwards.
	task put(input logic [7:0] d, input logic p, input logic f,
		input logic b);
		@(posedge i_clk);
		o_rx <= {1'b1, d, p, f, b};
		@(posedge i_clk);
		o_rx <= {1'b0, ~d, ~p, ~f, ~b};
	endtask

	// Modem levels; CTS high asks the block to stop sending.
	task modem(input logic [3:0] m);
		@(posedge i_clk);
		o_modem <= m;
	endtask
endmodule
`default_nettype wire

// ==== uart_line_modem_status_tb_top.sv ====
// Self-checking bench for the line and modem status block.
// Assumes the far model drives receiver, transmitter and modem inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ulm_consts.svh"
module uart_line_modem_status_tb_top;
	logic i_clk;
	logic i_arst_n;
	logic [3:0] i_addr;
	logic [7:0] i_wdata;
	logic i_we;
	logic i_re;
	logic [7:0] o_rdata;
	logic o_tx_valid;
	logic [7:0] o_tx_data;
	logic o_rts_n;
	logic o_dtr_n;
	logic o_loopback;
	logic o_baud_en;
	logic o_line_irq;
	logic o_thr_irq;
	logic o_modem_irq;
	logic rx_line;
	ulm_pkg::ulm_rx_evt_t rx;
	ulm_pkg::ulm_tx_stat_t tx;
	ulm_pkg::ulm_modem_in_t mdm;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;

	ulm_status #(.RX_DEPTH(4)) ulm_status_i (.i_clk(i_clk),
		.i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_rx(rx),
		.i_rx_line(rx_line), .i_tx(tx), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .i_modem(mdm), .o_rts_n(o_rts_n),
		.o_dtr_n(o_dtr_n), .o_loopback(o_loopback),
		.o_baud_en(o_baud_en), .o_line_irq(o_line_irq),
		.o_thr_irq(o_thr_irq), .o_modem_irq(o_modem_irq));

	ulm_far_model ulm_far_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_tx_valid(o_tx_valid), .i_rts_n(o_rts_n), .o_rx(rx),
		.o_rx_line(rx_line), .o_tx(tx), .o_modem(mdm));

	// Clock at 125 MHz.
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Hang guard.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end

	task summarize;
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Host bus cycles; each waits an edge before raising its strobe.
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_we <= 1'b0;
	endtask

	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_re <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_re <= 1'b0;
		#1 d = o_rdata;
	endtask

	task rc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	task wait_idle;
		int k;
		@(posedge i_clk);
		for (k = 0; k < 200 && (tx.busy || o_tx_valid); k++)
			@(posedge i_clk);
	endtask

	task t_regs;
		rc(`ULM_OFS_SP, `ULM_SP_RST);
		rc(`ULM_OFS_LS, 8'h60);
		rc(4'hF, 8'h00);
		wr(`ULM_OFS_SP, 8'hAA);
		rc(`ULM_OFS_SP, 8'hAA);
	endtask

	// Parity, framing and break characters, one at a time.
	task t_rx_err;
		logic [7:0] b;
		wr(`ULM_OFS_IE, 8'h04);
		for (int i = 0; i < 3; i++) begin
			b = 8'h04 << i;
			if (i == 2)
				ulm_far_model_i.o_rx_line = 1'b0;
			ulm_far_model_i.put(8'(8'h30 + i), i == 0, i == 1, i == 2);
			if (i == 2)
				ulm_far_model_i.put(8'h00, 1'b0, 1'b0, 1'b1);
			rc(`ULM_OFS_LS, 8'hE1 | b);
			chk({7'h0, o_line_irq}, 8'h01);
			rc(`ULM_OFS_DATA, 8'(8'h30 + i));
			rc(`ULM_OFS_LS, (i == 2) ? 8'h70 : 8'h60);
		end
		ulm_far_model_i.o_rx_line = 1'b1;
		rc(`ULM_OFS_LS, 8'h60);
	endtask

	task t_overrun;
		for (int i = 0; i < 5; i++)
			ulm_far_model_i.put(8'(8'h10 + i), 1'b0, 1'b0, 1'b0);
		rc(`ULM_OFS_LS, 8'h63);
		for (int i = 0; i < 4; i++)
			rc(`ULM_OFS_DATA, 8'(8'h10 + i));
		rc(`ULM_OFS_LS, 8'h60);
	endtask

	task t_modem;
		logic [7:0] d;
		wr(`ULM_OFS_IE, 8'h08);
		rc(`ULM_OFS_MS, 8'h00);
		ulm_far_model_i.modem(4'h0);
		repeat (3) @(posedge i_clk);
		#1 chk({7'h0, o_modem_irq}, 8'h01);
		rc(`ULM_OFS_MS, 8'hFB);
		rc(`ULM_OFS_MS, 8'hF0);
		@(posedge i_clk);
		#1 chk({7'h0, o_modem_irq}, 8'h00);
		ulm_far_model_i.modem(4'h2);
		repeat (2) @(posedge i_clk);
		rc(`ULM_OFS_MS, 8'hB4);
		ulm_far_model_i.modem(4'h0);
		repeat (2) @(posedge i_clk);
		rc(`ULM_OFS_MS, 8'hF0);
		wr(`ULM_OFS_MC, 8'h1D);
		// The modem outputs are registered one edge after the write lands.
		@(posedge i_clk);
		#1 chk({6'h0, o_loopback, o_dtr_n}, 8'h02);
		rd(`ULM_OFS_MS, d);
		chk(d & 8'hF0, 8'hE0);
		wr(`ULM_OFS_MC, 8'h00);
		rd(`ULM_OFS_MS, d);
		chk(d & 8'hF0, 8'hF0);
	endtask

	task count_baud(input logic [7:0] e);
		int n;
		n = 0;
		repeat (8) begin
			@(posedge i_clk);
			#1 n += o_baud_en;
		end
		chk(8'(n), e);
	endtask

	task t_presc;
		count_baud(8'h08);
		wr(`ULM_OFS_EF, 8'h10);
		wr(`ULM_OFS_MC, 8'h80);
		count_baud(8'h02);
		wr(`ULM_OFS_MC, 8'h00);
		wr(`ULM_OFS_EF, 8'h00);
	endtask

	task t_tx;
		int k;
		wr(`ULM_OFS_IE, 8'h02);
		ulm_far_model_i.hold = 1'b1;
		wr(`ULM_OFS_DATA, 8'hA5);
		rc(`ULM_OFS_LS, 8'h00);
		chk(o_tx_data, 8'hA5);
		chk({7'h0, o_thr_irq}, 8'h00);
		ulm_far_model_i.hold = 1'b0;
		for (k = 0; k < 20 && !tx.busy; k++)
			@(posedge i_clk);
		rc(`ULM_OFS_LS, 8'h20);
		chk({7'h0, o_thr_irq}, 8'h01);
		wait_idle();
		rc(`ULM_OFS_LS, 8'h60);
	endtask

	task t_cts;
		int k;
		wr(`ULM_OFS_EF, 8'h90);
		ulm_far_model_i.modem(4'h8);
		wr(`ULM_OFS_DATA, 8'h5A);
		repeat (4) @(posedge i_clk);
		#1 chk({7'h0, o_tx_valid}, 8'h00);
		ulm_far_model_i.modem(4'h0);
		for (k = 0; k < 20 && !tx.busy; k++)
			@(posedge i_clk);
		chk({7'h0, tx.busy}, 8'h01);
		wait_idle();
		wr(`ULM_OFS_EF, 8'h00);
	endtask

	task t_485;
		wr(`ULM_OFS_FC, 8'h20);
		wr(`ULM_OFS_MS, 8'h20);
		wr(`ULM_OFS_DATA, 8'h01);
		@(posedge i_clk);
		#1 chk({7'h0, o_rts_n}, 8'h01);
		wait_idle();
		repeat (12) @(posedge i_clk);
		chk(8'(ulm_far_model_i.rts_lat), 8'h01);
		wr(`ULM_OFS_EF, 8'h10);
		wr(`ULM_OFS_MS, 8'h20);
		wr(`ULM_OFS_DATA, 8'h02);
		wait_idle();
		repeat (12) @(posedge i_clk);
		chk(8'(ulm_far_model_i.rts_lat), 8'h08);
		wr(`ULM_OFS_FC, 8'h00);
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		i_arst_n = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_we = 1'b0;
		i_re = 1'b0;
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		t_regs();
		t_rx_err();
		t_overrun();
		t_modem();
		t_presc();
		t_tx();
		t_cts();
		t_485();
		summarize();
	end
endmodule
`default_nettype wire
